/* File: awd_pkg.sv */
/*
 * Shared constants for the auxiliary watchdog timer: register indexes,
 * field positions, reset values, timebase counts and the timer states.
 * Assumes a single 20 MHz clock feeding every module of the block.
 */
package awd_pkg;

    // Timebase
    localparam int CLK_HZ = 20_000_000;
    localparam int SEC_TIME_S = 1;
    localparam int CYC_PER_SEC = SEC_TIME_S * CLK_HZ;
    localparam int SECS_PER_MIN = 60;
    localparam int PRE_W = 25;
    localparam int MIN_W = 6;

    // Bus and register widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int IRQ_W = 16;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_UNIT = 8'hF1;
    localparam logic [7:0] IDX_VAL = 8'hF2;
    localparam logic [7:0] IDX_CFG = 8'hF3;
    localparam logic [7:0] IDX_CTRL = 8'hF4;
    localparam logic [ADDR_W-1:0] ADDR_UNIT = {2'h0, IDX_UNIT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_VAL = {2'h0, IDX_VAL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CFG = {2'h0, IDX_CFG, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [REG_W-1:0] REG_RST = 8'h00;

    // Field positions
    localparam int UNIT_SEC_BIT = 7;
    localparam int CFG_GAME_BIT = 0;
    localparam int CFG_KBD_BIT = 1;
    localparam int CFG_MOUSE_BIT = 2;
    localparam int CFG_MAP_LSB = 4;
    localparam int MAP_W = 4;
    localparam int CTRL_STAT_BIT = 0;
    localparam int CTRL_FORCE_BIT = 2;
    localparam int CTRL_EXT_BIT = 3;
    localparam logic [MAP_W-1:0] MAP_OFF = 4'h0;
    localparam logic [MAP_W-1:0] MAP_BAD = 4'h2;

    // Activity inputs, in synchroniser order
    localparam int EV_GAME = 0;
    localparam int EV_KBD = 1;
    localparam int EV_MOUSE = 2;
    localparam int EV_KBC = 3;
    localparam int EV_W = 4;

    typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_DONE} awd_state_e;

endpackage : awd_pkg

/* File: awd_evt_if.sv */
/*
 * Carrier between the watchdog core and its input synchroniser:
 * raw asynchronous levels in, one-cycle rising-edge pulses out.
 * Assumes both ends share the core clock.
 */
`timescale 1ns/10ps
interface awd_evt_if #(parameter int W = 4);
    logic [W-1:0] raw;
    logic [W-1:0] rise;
    modport sync (input raw, output rise);
    modport core (output raw, input rise);
endinterface : awd_evt_if

/* File: awd_sync.sv */
/*
 * Three-flop synchroniser with a settled-level tracker and rising-edge
 * pulse for each of W asynchronous inputs.
 * Assumes inputs are unrelated to pclk; a change counts once the second
 * and third stages agree.
 */
`timescale 1ns/10ps
module awd_sync #(
    parameter int W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    awd_evt_if.sync evt
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] lvl_r;
    logic [W-1:0] agree;

    // Three synchronising stages; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= evt.raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign agree = ~(s2_r ^ s3_r);

    // Settled level follows the last two stages only when they agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_r <= '0;
        end else begin
            lvl_r <= (agree & s3_r) | (~agree & lvl_r);
        end
    end

    // One pulse per settled rise, however long the input stays high
    assign evt.rise = agree & s3_r & ~lvl_r;

endmodule : awd_sync

/* File: awd_top.sv */
/*
 * Auxiliary watchdog timer with an APB register slave: minute or second
 * timebase, activity restarts, forced timeouts and an IRQ line selector.
 * Assumes a 20 MHz pclk, asynchronous activity inputs and a zero-wait
 * APB master; registers sit at four times their index.
 */
`timescale 1ns/10ps
module awd_top #(
    parameter int TICKS_PER_SEC = awd_pkg::CYC_PER_SEC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [awd_pkg::ADDR_W-1:0] paddr,
    input wire logic [awd_pkg::DATA_W-1:0] pwdata,
    output logic [awd_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic game_port_access,
    input wire logic kbd_irq,
    input wire logic mouse_irq,
    input wire logic kbc_reset_output,
    output logic [awd_pkg::IRQ_W-1:0] irq_out,
    output logic timeout_status
);

    localparam logic [awd_pkg::PRE_W-1:0] PRE_LAST =
        awd_pkg::PRE_W'(TICKS_PER_SEC - 1);
    localparam logic [awd_pkg::MIN_W-1:0] MIN_LAST =
        awd_pkg::MIN_W'(awd_pkg::SECS_PER_MIN - 1);

    awd_evt_if #(.W(awd_pkg::EV_W)) evt ();

    logic unit_sec_r;
    logic [awd_pkg::REG_W-1:0] val_r;
    logic cfg_game_r, cfg_kbd_r, cfg_mouse_r;
    logic [awd_pkg::MAP_W-1:0] map_r;
    logic status_r;
    logic ext_en_r;
    logic [awd_pkg::REG_W-1:0] cnt_r;
    logic [awd_pkg::PRE_W-1:0] pre_r;
    logic [awd_pkg::MIN_W-1:0] min_r;
    awd_pkg::awd_state_e st_r;
    logic [awd_pkg::IRQ_W-1:0] irq_r;
    logic [awd_pkg::DATA_W-1:0] prdata_r;
    logic pslverr_r;
    logic setup, acc_wr;
    logic wr_unit, wr_val, wr_cfg, wr_ctrl;
    logic sw_force, kbc_force, restart, reload;
    logic [awd_pkg::REG_W-1:0] load_val;
    logic sec_tick, min_tick, unit_tick;
    logic cnt_expire, timeout_evt;

    // Activity inputs pass the synchroniser and edge detector
    assign evt.raw = {kbc_reset_output, mouse_irq, kbd_irq, game_port_access};

    awd_sync #(.W(awd_pkg::EV_W)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .evt(evt)
    );

    // APB decode; zero wait states, writes land at the access edge
    assign pready = 1'b1;
    assign setup = psel & ~penable;
    assign acc_wr = psel & penable & pwrite;
    assign wr_unit = acc_wr & (paddr == awd_pkg::ADDR_UNIT);
    assign wr_val = acc_wr & (paddr == awd_pkg::ADDR_VAL);
    assign wr_cfg = acc_wr & (paddr == awd_pkg::ADDR_CFG);
    assign wr_ctrl = acc_wr & (paddr == awd_pkg::ADDR_CTRL);

    // Timeout causes: soft force, external edge, counted expiry
    assign sw_force = wr_ctrl & pwdata[awd_pkg::CTRL_FORCE_BIT];
    assign kbc_force = evt.rise[awd_pkg::EV_KBC] & ext_en_r;
    assign timeout_evt = cnt_expire | sw_force | kbc_force;

    // Restart sources gated by their enables
    assign restart = (evt.rise[awd_pkg::EV_GAME] & cfg_game_r)
        | (evt.rise[awd_pkg::EV_KBD] & cfg_kbd_r)
        | (evt.rise[awd_pkg::EV_MOUSE] & cfg_mouse_r);
    assign reload = restart | wr_val | wr_unit;
    assign load_val = wr_val ? pwdata[awd_pkg::REG_W-1:0] : val_r;

    // Timebase ticks and unit choice
    assign sec_tick = (pre_r == PRE_LAST);
    assign min_tick = sec_tick & (min_r == MIN_LAST);
    assign unit_tick = unit_sec_r ? sec_tick : min_tick;
    assign cnt_expire = (st_r == awd_pkg::ST_RUN) & unit_tick
        & (cnt_r == 8'h01) & ~reload;

    // Unit, value and configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_sec_r <= 1'b0;
            val_r <= awd_pkg::REG_RST;
            cfg_game_r <= 1'b0;
            cfg_kbd_r <= 1'b0;
            cfg_mouse_r <= 1'b0;
            map_r <= awd_pkg::MAP_OFF;
            ext_en_r <= 1'b0;
        end else begin
            if (wr_unit) begin
                unit_sec_r <= pwdata[awd_pkg::UNIT_SEC_BIT];
            end
            if (wr_val) begin
                val_r <= pwdata[awd_pkg::REG_W-1:0];
            end
            if (wr_cfg) begin
                cfg_game_r <= pwdata[awd_pkg::CFG_GAME_BIT];
                cfg_kbd_r <= pwdata[awd_pkg::CFG_KBD_BIT];
                cfg_mouse_r <= pwdata[awd_pkg::CFG_MOUSE_BIT];
                map_r <= pwdata[awd_pkg::CFG_MAP_LSB +: awd_pkg::MAP_W];
            end
            if (wr_ctrl) begin
                ext_en_r <= pwdata[awd_pkg::CTRL_EXT_BIT];
            end
        end
    end

    // Status bit: a timeout in the write cycle beats a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= 1'b0;
        end else if (timeout_evt) begin
            status_r <= 1'b1;
        end else if (wr_ctrl) begin
            status_r <= pwdata[awd_pkg::CTRL_STAT_BIT];
        end
    end

    // Prescalers restart with every reload so a full unit elapses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= '0;
            min_r <= '0;
        end else if (reload || sec_tick) begin
            pre_r <= '0;
            if (reload || min_tick) begin
                min_r <= '0;
            end else begin
                min_r <= min_r + 6'h01;
            end
        end else begin
            pre_r <= pre_r + 25'h0000001;
        end
    end

    // Count state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= awd_pkg::ST_OFF;
            cnt_r <= awd_pkg::REG_RST;
        end else if (reload) begin
            cnt_r <= load_val;
            if (load_val == 8'h00) begin
                st_r <= awd_pkg::ST_OFF;
            end else begin
                st_r <= awd_pkg::ST_RUN;
            end
        end else begin
            case (st_r)
                awd_pkg::ST_RUN: begin
                    if (unit_tick) begin
                        cnt_r <= cnt_r - 8'h01;
                        if (cnt_r == 8'h01) begin
                            st_r <= awd_pkg::ST_DONE;
                        end
                    end
                end
                awd_pkg::ST_OFF, awd_pkg::ST_DONE: begin
                    st_r <= st_r; // Idle until the next reload
                end
                default: begin
                    st_r <= awd_pkg::ST_OFF;
                end
            endcase
        end
    end

    // Interrupt line selector; invalid or zero code drives nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= '0;
        end else if (status_r && map_r != awd_pkg::MAP_OFF
                     && map_r != awd_pkg::MAP_BAD) begin
            irq_r <= 16'h0001 << map_r;
        end else begin
            irq_r <= '0;
        end
    end

    // Read data captured in the setup cycle; reserved bits read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= 1'b0;
            prdata_r <= '0;
            case (paddr)
                awd_pkg::ADDR_UNIT: begin
                    prdata_r[awd_pkg::UNIT_SEC_BIT] <= unit_sec_r;
                end
                awd_pkg::ADDR_VAL: begin
                    prdata_r[awd_pkg::REG_W-1:0] <= val_r;
                end
                awd_pkg::ADDR_CFG: begin
                    prdata_r[awd_pkg::CFG_GAME_BIT] <= cfg_game_r;
                    prdata_r[awd_pkg::CFG_KBD_BIT] <= cfg_kbd_r;
                    prdata_r[awd_pkg::CFG_MOUSE_BIT] <= cfg_mouse_r;
                    prdata_r[awd_pkg::CFG_MAP_LSB +: awd_pkg::MAP_W] <= map_r;
                end
                awd_pkg::ADDR_CTRL: begin
                    prdata_r[awd_pkg::CTRL_STAT_BIT] <= status_r;
                    prdata_r[awd_pkg::CTRL_EXT_BIT] <= ext_en_r;
                end
                default: begin
                    pslverr_r <= 1'b1;
                end
            endcase
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign irq_out = irq_r;
    assign timeout_status = status_r;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_unit_min;
        (!unit_sec_r && sec_tick && !min_tick && !reload) |=> $stable(cnt_r);
    endproperty
    a_unit_min: assert property (p_unit_min)
        else $error("count moved on a second tick in minute mode");
    property p_zero_off;
        (reload && load_val == 8'h00)
            |=> (st_r == awd_pkg::ST_OFF) && !cnt_expire;
    endproperty
    a_zero_off: assert property (p_zero_off)
        else $error("zero value left the counter running");
    property p_dec;
        (st_r == awd_pkg::ST_RUN && unit_tick && cnt_r > 8'h01 && !reload)
            |=> cnt_r == $past(cnt_r) - 8'h01;
    endproperty
    a_dec: assert property (p_dec)
        else $error("count did not step down by one unit");
    property p_game;
        (evt.rise[awd_pkg::EV_GAME] && cfg_game_r && !wr_val)
            |=> cnt_r == $past(val_r);
    endproperty
    a_game: assert property (p_game)
        else $error("game access did not restart count");
    property p_kbd;
        (evt.rise[awd_pkg::EV_KBD] && cfg_kbd_r && !wr_val)
            |=> cnt_r == $past(val_r);
    endproperty
    a_kbd: assert property (p_kbd)
        else $error("keyboard irq did not restart count");
    property p_mouse;
        (evt.rise[awd_pkg::EV_MOUSE] && cfg_mouse_r && !wr_val)
            |=> cnt_r == $past(val_r);
    endproperty
    a_mouse: assert property (p_mouse)
        else $error("mouse irq did not restart count");
    property p_bad_map;
        (map_r == awd_pkg::MAP_BAD) |=> irq_r == 16'h0000;
    endproperty
    a_bad_map: assert property (p_bad_map)
        else $error("invalid map code drove a line");
    property p_sticky;
        (status_r && !wr_ctrl) |=> status_r;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("status dropped without a write");
    property p_force;
        (wr_ctrl && pwdata[awd_pkg::CTRL_FORCE_BIT]) |=> status_r;
    endproperty
    a_force: assert property (p_force)
        else $error("force bit did not time out");
    property p_ext_off;
        (!ext_en_r && !status_r && !sw_force && !cnt_expire && !wr_ctrl)
            |=> !status_r;
    endproperty
    a_ext_off: assert property (p_ext_off)
        else $error("kbc activity forced a timeout while disabled");
    property p_kbc_pulse;
        evt.rise[awd_pkg::EV_KBC] |=> !evt.rise[awd_pkg::EV_KBC];
    endproperty
    a_kbc_pulse: assert property (p_kbc_pulse)
        else $error("kbc edge pulse longer than one cycle");
    property p_rsv_unit;
        (setup && paddr == awd_pkg::ADDR_UNIT) |=> prdata_r[6:0] == 7'h00;
    endproperty
    a_rsv_unit: assert property (p_rsv_unit)
        else $error("reserved unit bits read nonzero");
    property p_irq3;
        (status_r && map_r == 4'h3) |=> irq_r[3];
    endproperty
    a_irq3: assert property (p_irq3)
        else $error("mapped line not driven after timeout");
    property p_load;
        wr_val |=> cnt_r == $past(pwdata[7:0]);
    endproperty
    a_load: assert property (p_load)
        else $error("value write did not reload count");
    c_expire: cover property (cnt_expire);
    c_soft: cover property (sw_force);
    c_kbc: cover property (kbc_force);
    c_irq: cover property (irq_r != 16'h0000);

endmodule : awd_top

/* File: awd_top_tb.sv */
/*
 * Self-checking testbench for the auxiliary watchdog timer top level.
 * Assumes awd_top with a short seconds tick, a zero-wait APB slave and
 * activity inputs that may be driven straight from the bench clock.
 */
`timescale 1ns/10ps
module awd_top_tb;
    localparam int TPS = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [awd_pkg::ADDR_W-1:0] paddr = '0;
    logic [awd_pkg::DATA_W-1:0] pwdata = '0;
    logic [awd_pkg::DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] act = 3'h0;
    logic kbc = 1'b0;
    logic [awd_pkg::IRQ_W-1:0] irq_out;
    logic timeout_status;
    int n_errors = 0;
    int checks = 0;

    // Bench clock, 50 ns period
    always #25 pclk = ~pclk;

    awd_top #(.TICKS_PER_SEC(TPS)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .game_port_access(act[0]), .kbd_irq(act[1]), .mouse_irq(act[2]),
        .kbc_reset_output(kbc), .irq_out(irq_out),
        .timeout_status(timeout_status)
    );

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rd_chk(input string what, input logic [11:0] a,
                          input logic [7:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 8'h00, rd, err);
        chk(what, rd, {24'h000000, exp});
        chk("pslverr", {31'h0, err}, 32'h0);
    endtask : rd_chk

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // Wait for status high, at most lim cycles
    task automatic wait_st(input int lim);
        int n;
        n = 0;
        while (timeout_status !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_st

    task automatic st_is(input logic exp);
        chk("timeout_status", {31'h0, timeout_status}, {31'h0, exp});
    endtask : st_is

    task automatic pulse(input int i);
        act[i] <= 1'b1;
        cyc(4);
        act[i] <= 1'b0;
        cyc(4);
    endtask : pulse

    task automatic t_regs();
        logic [31:0] rd;
        logic err;
        rd_chk("unit", awd_pkg::ADDR_UNIT, 8'h00);
        rd_chk("value", awd_pkg::ADDR_VAL, 8'h00);
        rd_chk("cfg", awd_pkg::ADDR_CFG, 8'h00);
        rd_chk("ctrl", awd_pkg::ADDR_CTRL, 8'h00);
        wr(awd_pkg::ADDR_UNIT, 8'hFF);
        rd_chk("unit", awd_pkg::ADDR_UNIT, 8'h80);
        wr(awd_pkg::ADDR_CFG, 8'h0F);
        rd_chk("cfg", awd_pkg::ADDR_CFG, 8'h07);
        wr(awd_pkg::ADDR_CTRL, 8'h09);
        rd_chk("ctrl", awd_pkg::ADDR_CTRL, 8'h09);
        wr(awd_pkg::ADDR_CTRL, 8'h00);
        rd_chk("ctrl", awd_pkg::ADDR_CTRL, 8'h00);
        apb(1'b0, 12'h010, 8'h00, rd, err);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_expire();
        logic [15:0] code [5] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'hF};
        logic [15:0] exp [5] = '{16'h0, 16'h2, 16'h0, 16'h8, 16'h8000};
        wr(awd_pkg::ADDR_VAL, 8'h00);
        cyc(100);
        st_is(1'b0);
        wr(awd_pkg::ADDR_CFG, 8'h30);
        wr(awd_pkg::ADDR_VAL, 8'h03);
        cyc(3 * TPS - 5);
        st_is(1'b0);
        wait_st(12);
        st_is(1'b1);
        cyc(2);
        chk("irq", {16'h0, irq_out}, 32'h8);
        rd_chk("ctrl", awd_pkg::ADDR_CTRL, 8'h01);
        for (int i = 0; i < 5; i++) begin
            wr(awd_pkg::ADDR_CFG, {code[i][3:0], 4'h0});
            cyc(2);
            chk("irq map", {16'h0, irq_out}, {16'h0, exp[i]});
        end
        wr(awd_pkg::ADDR_CTRL, 8'h00);
        wr(awd_pkg::ADDR_UNIT, 8'h00);
        wr(awd_pkg::ADDR_VAL, 8'h01);
        cyc(60 * TPS - 20);
        st_is(1'b0);
        wait_st(30);
        st_is(1'b1);
        wr(awd_pkg::ADDR_CTRL, 8'h00);
        $display("test expire done");
    endtask : t_expire

    task automatic t_restart();
        for (int s = 0; s < 3; s++) begin
            wr(awd_pkg::ADDR_UNIT, 8'h80);
            wr(awd_pkg::ADDR_CFG, 8'h01 << s);
            wr(awd_pkg::ADDR_VAL, 8'h03);
            wr(awd_pkg::ADDR_CTRL, 8'h00);
            repeat (4) begin
                cyc(15);
                pulse(s);
            end
            st_is(1'b0);
            wr(awd_pkg::ADDR_CFG, 8'h00);
            wr(awd_pkg::ADDR_VAL, 8'h03);
            cyc(15);
            pulse(s);
            wait_st(15);
            st_is(1'b1);
        end
        wr(awd_pkg::ADDR_VAL, 8'h00);
        wr(awd_pkg::ADDR_CTRL, 8'h00);
        $display("test restart done");
    endtask : t_restart

    task automatic t_force();
        wr(awd_pkg::ADDR_CTRL, 8'h04);
        wait_st(3);
        st_is(1'b1);
        rd_chk("ctrl", awd_pkg::ADDR_CTRL, 8'h01);
        wr(awd_pkg::ADDR_CTRL, 8'h00);
        kbc <= 1'b1;
        cyc(10);
        st_is(1'b0);
        wr(awd_pkg::ADDR_CTRL, 8'h08);
        cyc(10);
        st_is(1'b0);
        kbc <= 1'b0;
        cyc(4);
        kbc <= 1'b1;
        wait_st(8);
        st_is(1'b1);
        kbc <= 1'b0;
        wr(awd_pkg::ADDR_CTRL, 8'h08);
        cyc(1);
        st_is(1'b0);
        wr(awd_pkg::ADDR_CTRL, 8'h0C);
        wait_st(3);
        st_is(1'b1);
        rd_chk("ctrl", awd_pkg::ADDR_CTRL, 8'h09);
        wr(awd_pkg::ADDR_CTRL, 8'h00);
        $display("test force done");
    endtask : t_force

    // Mid-run reset clears every register and both outputs
    task automatic t_reset();
        wr(awd_pkg::ADDR_UNIT, 8'h80);
        wr(awd_pkg::ADDR_VAL, 8'h05);
        wr(awd_pkg::ADDR_CFG, 8'h37);
        wr(awd_pkg::ADDR_CTRL, 8'h09);
        cyc(3);
        chk("irq", {16'h0, irq_out}, 32'h8);
        presetn <= 1'b0;
        cyc(3);
        presetn <= 1'b1;
        chk("irq", {16'h0, irq_out}, 32'h0);
        st_is(1'b0);
        rd_chk("unit", awd_pkg::ADDR_UNIT, 8'h00);
        rd_chk("value", awd_pkg::ADDR_VAL, 8'h00);
        rd_chk("cfg", awd_pkg::ADDR_CFG, 8'h00);
        rd_chk("ctrl", awd_pkg::ADDR_CTRL, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // Main sequence
    initial begin
        cyc(8);
        presetn <= 1'b1;
        t_regs();
        t_expire();
        t_restart();
        t_force();
        t_reset();
        print_verdict();
    end

    // Watchdog against a hung run
    initial begin
        cyc(20000);
        n_errors++;
        print_verdict();
    end
endmodule : awd_top_tb
